// *** rtl/skl_pkg.sv ***
package skl_pkg;

  // ----------------------------------------
  // character and clocking
  // ----------------------------------------
  localparam int          CHAR_BITS     = 8;
  localparam int          FIFO_DEPTH    = 32;
  localparam int          DIV_W         = 8;
  localparam logic [7:0]  DUMMY_TX      = 8'hFF;
  localparam logic [7:0]  CHAR_ZERO     = 8'h00;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BIT_ZERO      = 4'h0;
  localparam logic [7:0]  DIV_ZERO      = 8'h00;
  localparam logic [7:0]  DIV_RESET     = 8'h03;
  localparam int          SYNC_STAGES   = 2;

  typedef enum logic [1:0] {
    SKL_IDLE,
    SKL_LOW,
    SKL_HIGH,
    SKL_GAP
  } skl_state_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       clk;
    logic       mosi;
    logic       selN;
  } skl_pins_out_t;

  typedef struct packed {
    logic [7:0] data;
    logic       collision;
  } skl_rx_word_t;

endpackage

// *** rtl/skl_fifo.sv ***
`timescale 1ns/100ps
module skl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          valid;
  } skl_fifo_st_t;

  skl_fifo_st_t st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWr, doRd;

  assign inReady  = (st.cnt != (AW+1)'(DEPTH));
  // valid is kept in a flop so the head flag leaves the block glitch free
  assign outValid = st.valid;
  assign outData  = mem[st.rp];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_comb begin
    next_st = st;
    if (doWr) begin
      next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + AW'(1);
    end
    if (doRd) begin
      next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + AW'(1);
    end
    next_st.cnt = st.cnt + (AW+1)'(doWr) - (AW+1)'(doRd);
    next_st.valid = (next_st.cnt != '0);
  end

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[st.wp] <= inData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// *** rtl/skl_spi_master.sv ***
`timescale 1ns/100ps
module skl_spi_master
  import skl_pkg::*;
#(
  parameter int DEPTH = skl_pkg::FIFO_DEPTH
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           clockDivider,
  input  wire logic [7:0]           txData,
  input  wire logic                 txWrite,
  output logic                      txBusy,
  output logic                      txCollision,
  output logic                      transferDone,
  output logic [7:0]                rxData,
  output logic                      rxCollision,
  output logic                      rxValid,
  input  wire logic                 rxReady,
  output logic                      serial_clock_pin_ch0,
  output logic                      master_out_line_ch0,
  input  wire logic                 master_in_line_ch0,
  input  wire logic                 select_input_n_ch0,
  output logic                      slaveSelectGpioN,
  input  wire logic                 packet_ready_n,
  output logic                      packetReady
);
  import skl_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    skl_state_t     fsm;
    logic [7:0]     txShift;
    logic [7:0]     rxShift;
    logic [3:0]     bitCnt;
    logic [7:0]     divCnt;
    logic [1:0]     misoSync;
    logic [1:0]     atnSync;
    logic [1:0]     ssSync;
    logic           sclk;
    logic           mosi;
    logic           selN;
    logic           busy;
    logic           done;
    logic           txColl;
    logic           pendColl;
    logic           pushValid;
    skl_rx_word_t   pushWord;
    logic           atn;
  } skl_st_t;

  skl_st_t st, next_st;
  logic    fifoInReady;
  logic    divHit;

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  skl_rx_word_t fifoOut;

  skl_fifo #(
    .WIDTH ($bits(skl_rx_word_t)),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inData   (st.pushWord),
    .inValid  (st.pushValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (rxValid),
    .outReady (rxReady)
  );

  assign rxData      = fifoOut.data;
  assign rxCollision = fifoOut.collision;
  assign divHit      = (st.divCnt == DIV_ZERO);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st          = st;
    next_st.done     = 1'b0;
    next_st.txColl   = 1'b0;
    next_st.misoSync = {st.misoSync[0], master_in_line_ch0};
    next_st.atnSync  = {st.atnSync[0], packet_ready_n};
    next_st.ssSync   = {st.ssSync[0], select_input_n_ch0};
    next_st.atn      = ~st.atnSync[1];
    if (st.pushValid && fifoInReady) begin
      next_st.pushValid = 1'b0;
    end
    if (txWrite && st.busy) begin
      next_st.txColl = 1'b1;
    end
    if (st.fsm != SKL_IDLE) begin
      next_st.divCnt = divHit ? clockDivider : st.divCnt - 8'h01;
    end
    case (st.fsm)
      SKL_IDLE: begin
        next_st.sclk = 1'b0;
        // a new character is dropped while the buffer holds an unsent byte
        if (txWrite && !st.pushValid) begin
          next_st.txShift  = txData;
          next_st.mosi     = txData[CHAR_BITS-1];
          next_st.selN     = 1'b0;
          next_st.busy     = 1'b1;
          next_st.bitCnt   = BIT_ZERO;
          next_st.divCnt   = clockDivider;
          next_st.pendColl = ~st.ssSync[1];
          next_st.fsm      = SKL_LOW;
        end
      end
      SKL_LOW: begin
        if (divHit) begin
          next_st.sclk    = 1'b1;
          next_st.rxShift = {st.rxShift[6:0], st.misoSync[1]};
          next_st.fsm     = SKL_HIGH;
        end
      end
      SKL_HIGH: begin
        if (divHit) begin
          next_st.sclk = 1'b0;
          if (st.bitCnt == BIT_LAST) begin
            next_st.selN  = 1'b1;
            next_st.fsm   = SKL_GAP;
          end else begin
            next_st.txShift = {st.txShift[6:0], 1'b0};
            next_st.mosi    = st.txShift[CHAR_BITS-2];
            next_st.bitCnt  = st.bitCnt + 4'h1;
            next_st.fsm     = SKL_LOW;
          end
        end
      end
      SKL_GAP: begin
        // one divider period with select high keeps characters apart
        if (divHit) begin
          next_st.busy      = 1'b0;
          next_st.done      = 1'b1;
          next_st.pushValid = 1'b1;
          next_st.pushWord  = '{data: st.rxShift, collision: st.pendColl};
          next_st.fsm       = SKL_IDLE;
        end
      end
      default: begin
        next_st.fsm = SKL_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st          <= '0;
      st.fsm      <= SKL_IDLE;
      st.txShift  <= DUMMY_TX;
      st.rxShift  <= CHAR_ZERO;
      st.divCnt   <= DIV_RESET;
      st.selN     <= 1'b1;
      st.atnSync  <= 2'b11;
      st.ssSync   <= 2'b11;
    end else begin
      st <= next_st;
    end
  end

  assign serial_clock_pin_ch0 = st.sclk;
  assign master_out_line_ch0  = st.mosi;
  assign slaveSelectGpioN     = st.selN;
  assign txBusy               = st.busy;
  assign txCollision          = st.txColl;
  assign transferDone         = st.done;
  assign packetReady          = st.atn;
endmodule

// *** dv/skl_spi_master_properties.sv ***
`timescale 1ns/100ps
module skl_spi_master_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txWrite,
  input wire logic txBusy,
  input wire logic txCollision,
  input wire logic transferDone,
  input wire logic rxValid,
  input wire logic serial_clock_pin_ch0,
  input wire logic master_out_line_ch0,
  input wire logic slaveSelectGpioN,
  input wire logic packet_ready_n,
  input wire logic packetReady
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] rises;
  logic       sclkQ;
  // counts clock rises of the current character
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rises <= 4'h0;
      sclkQ <= 1'b0;
    end else begin
      sclkQ <= serial_clock_pin_ch0;
      if (!txBusy) rises <= 4'h0;
      else if (serial_clock_pin_ch0 && !sclkQ) rises <= rises + 4'h1;
    end
  end
  a_sclk_idle: assert property (!txBusy |-> !serial_clock_pin_ch0)
    else $error("serial clock moved while idle");
  a_eight_pulses: assert property (transferDone |-> rises == 4'h8)
    else $error("character did not carry eight clock pulses");
  a_select_idle: assert property (!txBusy |-> slaveSelectGpioN)
    else $error("slave select low between characters");
  a_mosi_steady: assert property (serial_clock_pin_ch0 && $past(serial_clock_pin_ch0)
    |-> $stable(master_out_line_ch0))
    else $error("master out changed while clock high");
  a_start_cause: assert property ($rose(txBusy) |-> $past(txWrite))
    else $error("character started without a write");
  a_coll_cause: assert property (txCollision |-> $past(txWrite) && $past(txBusy))
    else $error("collision flagged without a busy write");
  a_done_push: assert property (transferDone |-> ##[1:3] rxValid)
    else $error("received byte not presented");
  a_ready_high: assert property ((!packet_ready_n)[*4] |-> packetReady)
    else $error("packet ready not followed");
  a_ready_low: assert property (packet_ready_n[*4] |-> !packetReady)
    else $error("packet ready stuck");
  cover property (transferDone);
  cover property (txCollision);
  cover property (packetReady);
endmodule

bind skl_spi_master skl_spi_master_properties i_props (.clk, .sys_rst, .txWrite, .txBusy,
  .txCollision, .transferDone, .rxValid, .serial_clock_pin_ch0, .master_out_line_ch0,
  .slaveSelectGpioN, .packet_ready_n, .packetReady);

// *** dv/skl_slave_model.sv ***
`timescale 1ns/100ps
module skl_slave_model (
  input wire logic       sclk,
  input wire logic       selN,
  input wire logic       mosi,
  input wire logic [7:0] reply,
  input wire logic       hasPacket,
  output logic           miso,
  output logic           packetReadyN,
  output logic [7:0]     heard
);
  logic [7:0] shift;
  // slave side, mode 0, msb first
  // released line shows the inverse, so a stale bit is never read as good
  assign miso = selN ? ~shift[7] : shift[7];
  assign packetReadyN = ~hasPacket;
  initial begin
    shift = 8'h00;
    heard = 8'h00;
  end
  always @(negedge selN) shift = reply;
  always @(posedge sclk) heard = {heard[6:0], mosi};
  always @(negedge sclk) shift = {shift[6:0], 1'b0};
endmodule

// *** dv/spi_master_keyboard_link_tb.sv ***
`timescale 1ns/100ps
module spi_master_keyboard_link_tb;
  import skl_pkg::*;
  logic       clk, sys_rst, txWrite, txBusy, txCollision, transferDone, rxCollision;
  logic       rxValid, rxReady, serial_clock_pin_ch0, master_out_line_ch0;
  logic       master_in_line_ch0, select_input_n_ch0, slaveSelectGpioN;
  logic       packet_ready_n, packetReady, hasPacket;
  logic [7:0] clockDivider, txData, rxData, reply, heard;
  int         err_total, tests_run, cycles;
  skl_spi_master i_dut (.clk, .sys_rst, .clockDivider, .txData, .txWrite, .txBusy,
    .txCollision, .transferDone, .rxData, .rxCollision, .rxValid, .rxReady,
    .serial_clock_pin_ch0, .master_out_line_ch0, .master_in_line_ch0,
    .select_input_n_ch0, .slaveSelectGpioN, .packet_ready_n, .packetReady);
  skl_slave_model i_slave (.sclk(serial_clock_pin_ch0), .selN(slaveSelectGpioN),
    .mosi(master_out_line_ch0), .reply, .hasPacket, .miso(master_in_line_ch0),
    .packetReadyN(packet_ready_n), .heard);
  task automatic chk(input string what, input logic [8:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [7:0] d);
    txData = d;
    txWrite = 1'b1;
    tick(1);
    txWrite = 1'b0;
  endtask
  task automatic wait_for(input int which);
    int n;
    n = 0;
    while ((which ? rxValid : transferDone) !== 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
    chk("handshake", {8'h00, n < 600}, 9'h001);
  endtask
  task automatic t_fill();
    rxReady = 1'b0;
    for (int i = 0; i < 32; i++) begin
      clockDivider = 8'h03 + 8'(i % 3);
      reply = 8'(i * 7);
      send(i == 0 ? DUMMY_TX : ~8'(i));
      wait_for(0);
      chk("heard", {1'b0, heard}, {1'b0, i == 0 ? DUMMY_TX : ~8'(i)});
      tick(1);
    end
    // a full buffer still lets one character run; its byte then waits to be pushed
    reply = 8'h66;
    send(8'hA5);
    wait_for(0);
    send(8'h5A);
    tick(2);
    chk("refused", {8'h00, txBusy}, 9'h000);
    chk("dropped", {1'b0, heard}, 9'h0A5);
    rxReady = 1'b1;
    for (int i = 0; i < 33; i++) begin
      wait_for(1);
      chk("rx", {rxCollision, rxData}, {1'b0, i < 32 ? 8'(i * 7) : 8'h66});
      tick(1);
    end
    chk("empty", {8'h00, rxValid}, 9'h000);
    $display("fill and drain done");
  endtask
  task automatic t_coll();
    send(8'h3C);
    tick(2);
    send(8'h55);
    chk("collision", {8'h00, txCollision}, 9'h001);
    wait_for(0);
    chk("kept", {1'b0, heard}, 9'h03C);
    tick(2);
    $display("collision done");
  endtask
  task automatic t_sel();
    rxReady = 1'b0;
    select_input_n_ch0 = 1'b0;
    // let the select input pass its two sync flops before the start
    tick(2);
    send(8'h81);
    wait_for(1);
    chk("sel flag", {8'h00, rxCollision}, 9'h001);
    chk("sel data", {1'b0, rxData}, 9'h066);
    select_input_n_ch0 = 1'b1;
    rxReady = 1'b1;
    tick(2);
    $display("select done");
  endtask
  task automatic t_atn();
    hasPacket = 1'b1;
    tick(5);
    chk("ready on", {8'h00, packetReady}, 9'h001);
    hasPacket = 1'b0;
    tick(5);
    chk("ready off", {8'h00, packetReady}, 9'h000);
    $display("packet ready done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    {sys_rst, txWrite, rxReady, hasPacket, select_input_n_ch0} = 5'b10001;
    {clockDivider, txData, reply} = 24'h030000;
    tick(8);
    sys_rst = 1'b0;
    chk("idle pins", {7'h00, serial_clock_pin_ch0, slaveSelectGpioN}, 9'h001);
    chk("idle flags", {7'h00, txBusy, rxValid}, 9'h000);
    t_fill();
    t_coll();
    t_sel();
    t_atn();
    end_sim();
  end
endmodule
